/* hw/issa_slave.sv */
`timescale 1ns/1ns
// Operation
// - Write control byte, then two address bytes
// - One shared pointer sets next access start
// - Store byte at acknowledge clock rising edge
// - Abort keeps acked bytes, drops unacked byte
// - Protected write: no ack, no increment, ignore
// - Write-protect pin guards upper quarter array
// - Write increments pointer, wraps, unlimited length
// - Read control byte starts at pointer
// - Master ack low continues, high ends
// - Pointer increments after every byte accessed
// - Master nack plus Stop, device releases line
// - Sequential read wraps to address zero
// - Control byte selector and chip-select match
// - Power-loss save aborts current access
module issa_slave #(
	parameter int FIFO_DEPTH = issa_pkg::FIFO_DEPTH
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic        wpPin,
	input  wire logic        chipSelectPinLow,
	input  wire logic        chipSelectPinHigh,
	input  wire logic        powerLossSave,
	output logic [12:0]      addrPointer
);

	// ============================================================
	// Pin synchronisers
	logic [5:0] pinMeta;                             // First stage only
	logic [5:0] pinSync;                             // Second stage
	logic       sclPrev;                             // Clock line last cycle
	logic       sdaPrev;                             // Data line last cycle

	// Two flops per pin, then one more on clock and data lines for edge finding
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta <= issa_pkg::SYNC_RST;
			pinSync <= issa_pkg::SYNC_RST;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			pinMeta <= {powerLossSave, wpPin, chipSelectPinHigh,
			            chipSelectPinLow, sclIn, sdaIn};
			pinSync <= pinMeta;
			sclPrev <= pinSync[issa_pkg::SY_SCL];
			sdaPrev <= pinSync[issa_pkg::SY_SDA];
		end
	end

	// ============================================================
	// Bus events
	logic sdaS;                                      // Data line, synchronised
	logic sclS;                                      // Clock line, synchronised
	logic wpS;                                       // Write protect level
	logic saveS;                                     // Save request level
	logic sclRise;                                   // Clock rising edge
	logic sclFall;                                   // Clock falling edge
	logic startCond;                                 // Start or repeated Start
	logic stopCond;                                  // Stop

	assign sdaS      = pinSync[issa_pkg::SY_SDA];
	assign sclS      = pinSync[issa_pkg::SY_SCL];
	assign wpS       = pinSync[issa_pkg::SY_WP];
	assign saveS     = pinSync[issa_pkg::SY_SAVE];
	assign sclRise   = sclS && !sclPrev;
	assign sclFall   = !sclS && sclPrev;
	assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
	assign stopCond  = sclS && sclPrev && !sdaPrev && sdaS;

	// ============================================================
	// Byte framing
	issa_pkg::issa_state_e state;                    // Transfer phase
	logic [3:0]            bitCnt;                   // Clock slot in byte
	logic [7:0]            shiftReg;                 // Received bits
	logic                  acked;                    // Ack given this byte
	logic                  rwBit;                    // Read selected
	logic                  ackRise;                  // Acknowledge clock rises
	logic                  ackFall;                  // Acknowledge clock ends
	logic                  lastFall;                 // Eighth bit ends
	logic                  ctrlMatch;                // Control byte addresses us
	logic                  protHit;                  // Pointer in guarded region
	logic                  ackNow;                   // Ack decision for this byte
	logic                  abortNow;                 // Any abort source
	logic                  slotOpen;                 // Clock rose in this slot
	logic                  fifoInReady;              // Room for a byte

	assign ackRise  = sclRise && bitCnt == issa_pkg::BIT_ACK;
	assign ackFall  = sclFall && bitCnt == issa_pkg::BIT_ACK;
	assign lastFall = sclFall && bitCnt == issa_pkg::BIT_LAST;
	assign abortNow = saveS || startCond || stopCond;

	// Selector, chip-select pins and fixed one bit all have to agree
	assign ctrlMatch = shiftReg[7:4] == issa_pkg::SEL_CODE
	                && shiftReg[issa_pkg::POS_CSH] == pinSync[issa_pkg::SY_CSH]
	                && shiftReg[issa_pkg::POS_CSL] == pinSync[issa_pkg::SY_CSL]
	                && shiftReg[issa_pkg::POS_ONE];

	// Upper quarter guarded only while the protect pin is high
	assign protHit = wpS && addrPointer >= issa_pkg::PROT_BASE;

	// Ack decision taken when the eighth bit has been clocked in
	always_comb begin
		unique case (state)
			issa_pkg::ST_CTRL:  ackNow = ctrlMatch;
			// Both address bytes always acknowledged, even when guarded
			issa_pkg::ST_ADDRH: ackNow = 1'b1;
			issa_pkg::ST_ADDRL: ackNow = 1'b1;
			// Guarded byte or full buffer gets no ack
			issa_pkg::ST_WDATA: ackNow = !protHit && fifoInReady;
			default:            ackNow = 1'b0;
		endcase
	end

	// Slot tracker: the clock fall that follows a Start carries no bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			slotOpen <= 1'b0;
		end else if (startCond || sclFall) begin
			slotOpen <= 1'b0;
		end else if (sclRise) begin
			slotOpen <= 1'b1;
		end
	end

	// Bit counter: nine clocks per byte, cleared by Start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bitCnt <= issa_pkg::BIT_FIRST;
		end else if (startCond) begin
			bitCnt <= issa_pkg::BIT_FIRST;
		end else if (sclFall && slotOpen) begin
			bitCnt <= ackFall ? issa_pkg::BIT_FIRST : bitCnt + 4'h1;
		end
	end

	// Receive shifter samples on rising clock in data slots
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shiftReg <= 8'h00;
		end else if (sclRise && bitCnt < issa_pkg::BIT_ACK) begin
			shiftReg <= {shiftReg[6:0], sdaS};
		end
	end

	// Ack outcome and direction latched at end of eighth bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			acked <= 1'b0;
			rwBit <= 1'b0;
		end else if (lastFall) begin
			acked <= ackNow;
			if (state == issa_pkg::ST_CTRL) begin
				rwBit <= shiftReg[issa_pkg::POS_RW];
			end
		end
	end

	// ============================================================
	// Phase sequencing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= issa_pkg::ST_IDLE;
		end else if (saveS) begin
			// Save takes the device off the bus mid-access
			state <= issa_pkg::ST_IGNORE;
		end else if (startCond) begin
			// Repeated Start ends a write after pointer load
			state <= issa_pkg::ST_CTRL;
		end else if (stopCond) begin
			state <= issa_pkg::ST_IDLE;
		end else if (ackRise) begin
			unique case (state)
				issa_pkg::ST_CTRL: begin
					if (!acked) begin
						state <= issa_pkg::ST_IGNORE;
					end else if (rwBit) begin
						state <= issa_pkg::ST_RDATA;
					end else begin
						state <= issa_pkg::ST_ADDRH;
					end
				end
				issa_pkg::ST_ADDRH: state <= issa_pkg::ST_ADDRL;
				issa_pkg::ST_ADDRL: state <= issa_pkg::ST_WDATA;
				issa_pkg::ST_WDATA: begin
					// Refused byte ends the write until next Start
					if (!acked) begin
						state <= issa_pkg::ST_IGNORE;
					end
				end
				issa_pkg::ST_RDATA: begin
					// Master high on ack ends the read
					if (sdaS) begin
						state <= issa_pkg::ST_IGNORE;
					end
				end
				issa_pkg::ST_IDLE:   state <= issa_pkg::ST_IDLE;
				issa_pkg::ST_IGNORE: state <= issa_pkg::ST_IGNORE;
				default:             state <= issa_pkg::ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// Write path: buffer between bus and array
	issa_pkg::issa_wr_s fifoIn;                      // Entry to queue
	issa_pkg::issa_wr_s fifoOut;                     // Entry to store
	logic               fifoPush;                    // Byte committed
	logic               fifoOutValid;                // Entry waiting
	logic               fetchPend;                   // Read byte wanted
	logic               memRe;                       // Array read issued
	logic               memWe;                       // Array write issued
	logic               memRdValid;                  // Read data arrives
	logic [7:0]         memRdata;                    // Array read data

	// Commit only on the acknowledge rising edge, never earlier
	assign fifoPush = ackRise && state == issa_pkg::ST_WDATA
	               && acked && !saveS;
	assign fifoIn   = '{addr: addrPointer, data: shiftReg};
	// Reads wait for queued writes, so data read back is current
	assign memRe    = fetchPend && !fifoOutValid;
	assign memWe    = fifoOutValid && !fetchPend;

	issa_fifo #(
		.W     ($bits(issa_pkg::issa_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (sys_clk),
		.nrst     (nrst),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (!fetchPend),
		.outData  (fifoOut)
	);

	issa_mem #(
		.AW (issa_pkg::ADDR_W),
		.DW (issa_pkg::DATA_W)
	) u_mem (
		.clk   (sys_clk),
		.we    (memWe),
		.waddr (fifoOut.addr),
		.wdata (fifoOut.data),
		.re    (memRe),
		.raddr (addrPointer),
		.rdata (memRdata)
	);

	// ============================================================
	// Shared address pointer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addrPointer <= issa_pkg::PTR_RST;
		end else if (ackRise && state == issa_pkg::ST_ADDRH) begin
			// Only low five bits of high byte are kept
			addrPointer[12:8] <= shiftReg[4:0];
		end else if (ackRise && state == issa_pkg::ST_ADDRL) begin
			addrPointer[7:0] <= shiftReg;
		end else if (fifoPush || memRe) begin
			// One step per byte, natural wrap from top to zero
			addrPointer <= addrPointer + 13'h0001;
		end
	end

	// ============================================================
	// Read path
	logic [7:0] txReg;                               // Byte being sent

	// Fetch request raised by control ack or master ack
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fetchPend <= 1'b0;
		end else if (abortNow) begin
			fetchPend <= 1'b0;
		end else if (ackRise && ((state == issa_pkg::ST_CTRL && acked && rwBit)
		          || (state == issa_pkg::ST_RDATA && !sdaS))) begin
			fetchPend <= 1'b1;
		end else if (memRe) begin
			fetchPend <= 1'b0;
		end
	end

	// Read data valid one cycle after the request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			memRdValid <= 1'b0;
		end else begin
			memRdValid <= memRe;
		end
	end

	// Transmit shifter: load from array, shift on each driven bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txReg <= 8'h00;
		end else if (memRdValid) begin
			txReg <= memRdata;
		end else if (state == issa_pkg::ST_RDATA
		          && (ackFall || (sclFall && bitCnt < issa_pkg::BIT_LAST))) begin
			txReg <= {txReg[6:0], 1'b0};
		end
	end

	// ============================================================
	// Open-drain data line: low level only, enable pulls it down
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// Drive changes only while the clock is low, except the release on an abort
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sdaOe <= 1'b0;
		end else if (abortNow) begin
			sdaOe <= 1'b0;
		end else if (lastFall) begin
			// Ack slot: pull low when accepting, release when reading
			sdaOe <= ackNow;
		end else if (ackFall) begin
			sdaOe <= state == issa_pkg::ST_RDATA && !txReg[7];
		end else if (sclFall && state == issa_pkg::ST_RDATA) begin
			sdaOe <= !txReg[7];
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	write_commit_a: assert property (fifoPush |-> sclRise && bitCnt == 4'h8)
		else $error("write committed outside acknowledge rising edge");

	abort_drop_a: assert property (saveS |-> !fifoPush)
		else $error("byte committed during abort");

	prot_halt_a: assert property (
		(ackRise && state == issa_pkg::ST_WDATA && !acked && !abortNow)
		|=> state == issa_pkg::ST_IGNORE && addrPointer == $past(addrPointer))
		else $error("refused write did not halt");

	prot_nack_a: assert property (
		(lastFall && state == issa_pkg::ST_WDATA && wpS && addrPointer >= 13'h1800
		 && !abortNow) |=> !sdaOe)
		else $error("guarded byte was acknowledged");

	ptr_step_a: assert property (
		fifoPush |=> addrPointer == 13'($past(addrPointer) + 13'h0001))
		else $error("pointer did not advance after write");

	read_step_a: assert property (
		memRe |=> addrPointer == 13'($past(addrPointer) + 13'h0001) && memRdValid)
		else $error("pointer did not advance after read");

	addr_load_a: assert property (
		(ackRise && state == issa_pkg::ST_ADDRH && !abortNow)
		|=> addrPointer[12:8] == $past(shiftReg[4:0]))
		else $error("high address bits not loaded");

	ctrl_match_a: assert property (
		(lastFall && state == issa_pkg::ST_CTRL && shiftReg[7:4] != 4'ha && !abortNow)
		|=> !sdaOe)
		else $error("foreign control byte acknowledged");

	read_end_a: assert property (
		(ackRise && state == issa_pkg::ST_RDATA && sdaS && !abortNow)
		|=> state == issa_pkg::ST_IGNORE && !fetchPend)
		else $error("read not ended by master release");

	save_abort_a: assert property (
		saveS |=> state == issa_pkg::ST_IGNORE && !sdaOe)
		else $error("save request did not abort access");

endmodule : issa_slave

/* hw/issa_pkg.sv */
package issa_pkg;

	// ============================================================
	// Array geometry
	localparam int          ADDR_W    = 13;          // Pointer width
	localparam int          DATA_W    = 8;           // Array word width
	localparam logic [12:0] PTR_RST   = 13'h0000;    // Pointer after reset
	localparam logic [12:0] PROT_BASE = 13'h1800;    // First address of upper quarter

	// ============================================================
	// Control byte decode
	localparam logic [3:0]  SEL_CODE  = 4'ha;        // Array selector nibble
	localparam int          POS_CSH   = 3;           // High chip-select bit
	localparam int          POS_CSL   = 2;           // Low chip-select bit
	localparam int          POS_ONE   = 1;           // Fixed one bit
	localparam int          POS_RW    = 0;           // Read/write bit

	// ============================================================
	// Bit counter positions inside one nine-clock byte slot
	localparam logic [3:0]  BIT_FIRST = 4'h0;        // First data bit
	localparam logic [3:0]  BIT_LAST  = 4'h7;        // Eighth data bit
	localparam logic [3:0]  BIT_ACK   = 4'h8;        // Acknowledge clock

	// ============================================================
	// Synchroniser layout and reset value (bus lines idle high)
	localparam int          SYN_W     = 6;           // Synchronised pins
	localparam int          SY_SDA    = 0;           // Data line
	localparam int          SY_SCL    = 1;           // Clock line
	localparam int          SY_CSL    = 2;           // Low chip-select pin
	localparam int          SY_CSH    = 3;           // High chip-select pin
	localparam int          SY_WP     = 4;           // Write-protect pin
	localparam int          SY_SAVE   = 5;           // Power-loss save request
	localparam logic [5:0]  SYNC_RST  = 6'h03;       // Lines high, rest low

	// ============================================================
	// Write buffer
	localparam int          FIFO_DEPTH = 8;          // Pending write entries

	// ============================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,                          // Bus free
		ST_CTRL   = 3'b001,                          // Receiving control byte
		ST_ADDRH  = 3'b010,                          // Receiving high address
		ST_ADDRL  = 3'b011,                          // Receiving low address
		ST_WDATA  = 3'b100,                          // Receiving write data
		ST_RDATA  = 3'b101,                          // Sending read data
		ST_IGNORE = 3'b110                           // Deaf until next Start
	} issa_state_e;

	typedef struct packed {
		logic [12:0] addr;                           // Target location
		logic [7:0]  data;                           // Byte to store
	} issa_wr_s;

endpackage : issa_pkg

/* hw/issa_fifo.sv */
`timescale 1ns/1ns
module issa_fifo #(
	parameter int W     = 21,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);

	// ============================================================
	// Storage and pointers (DEPTH a power of two, pointers wrap freely)
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  store [DEPTH];                    // Entry storage
	logic [AW-1:0] wrPtr;                            // Next slot to fill
	logic [AW-1:0] rdPtr;                            // Oldest entry
	logic [AW:0]   count;                            // Entries held
	logic          doPush;                           // Accepted push
	logic          doPop;                            // Accepted pop

	assign inReady  = count != (AW+1)'(DEPTH);
	assign outValid = count != '0;
	assign outData  = store[rdPtr];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// Entry write, no reset on the data itself
	always_ff @(posedge clk) begin
		if (doPush) begin
			store[wrPtr] <= inData;
		end
	end

	// Pointer and fill level bookkeeping
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doPush) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doPop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end

endmodule : issa_fifo

/* hw/issa_mem.sv */
`timescale 1ns/1ns
module issa_mem #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic [DW-1:0]      rdata
);

	// ============================================================
	// Array, read data registered one cycle after the request
	logic [DW-1:0] cells [2**AW];                    // Byte array

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	// Read port
	always_ff @(posedge clk) begin
		if (re) begin
			rdata <= cells[raddr];
		end
	end

endmodule : issa_mem

/* tb/issa_master.sv */
`timescale 1ns/1ns
// ============================================================
// Bus master model, open-drain data line with pull-up
module issa_master (
	input  wire logic sys_clk,
	input  wire logic sdaOe,
	output logic      scl,
	output logic      sdaWire
);
	logic sdaDrv; // Master level, high = released

	// Wired-and of both parties, pulled up when released
	assign sdaWire = sdaDrv & ~sdaOe;

	// Idle bus: both lines high
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	// Wait a number of system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	// One clock pulse: data set in low phase, line sampled late in high phase
	task automatic bitx(input logic b, output logic r);
		sdaDrv <= b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		r = sdaWire;
		tick(1);
		scl <= 1'b0;
		tick(1);
	endtask : bitx

	// Start or repeated Start; waits for any ack drive to be released first
	task automatic start;
		sdaDrv <= 1'b1;
		tick(5);
		scl <= 1'b1;
		tick(4);
		sdaDrv <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(1);
	endtask : start

	// Stop condition ends every operation
	task automatic stop;
		sdaDrv <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(4);
		sdaDrv <= 1'b1;
		tick(8);
	endtask : stop

	// Byte out MSB first; without the ack clock when full is low
	task automatic sendByte(input logic [7:0] d, input logic full, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		ack = 1'b0;
		if (full) begin
			bitx(1'b1, r);
			ack = ~r;
		end
	endtask : sendByte

	// Byte in MSB first, then master ack level
	task automatic recvByte(input logic mAck, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(mAck, r);
	endtask : recvByte
endmodule : issa_master

/* tb/tb.sv */
`timescale 1ns/1ns
// ============================================================
// Top-level bench
module tb;
	logic        sys_clk = 1'b0;           // System clock
	logic        nrst = 1'b0;              // Reset, active low
	logic        wpPin = 1'b0;             // Write protect
	logic        chipSelectPinLow = 1'b1;  // Low strap
	logic        chipSelectPinHigh = 1'b0; // High strap
	logic        powerLossSave = 1'b0;     // Save request
	logic        scl;                      // Bus clock
	logic        sdaWire;                  // Bus data
	logic        sdaOe;                    // Device pulls data low
	logic        sdaOut;                   // Device drive level
	logic [12:0] ptr;                      // Address pointer
	logic        ack;                      // Last ack seen
	logic [7:0]  rd;                       // Last byte read
	logic [7:0]  badCtrl [4] = '{8'ha2, 8'hae, 8'ha4, 8'hb6}; // Refused controls
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;

	always #25 sys_clk = ~sys_clk;

	issa_slave i_dut (.sys_clk(sys_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .wpPin(wpPin), .chipSelectPinLow(chipSelectPinLow),
		.chipSelectPinHigh(chipSelectPinHigh), .powerLossSave(powerLossSave),
		.addrPointer(ptr));
	issa_master i_mst (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaWire(sdaWire));

	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Write control byte and two address bytes
	task automatic setPtr(input logic [15:0] a);
		i_mst.start();
		i_mst.sendByte(8'ha6, 1'b1, ack);
		check("ctrl ack", ack, 1'b1);
		i_mst.sendByte(a[15:8], 1'b1, ack);
		check("addr hi ack", ack, 1'b1);
		i_mst.sendByte(a[7:0], 1'b1, ack);
		check("addr lo ack", ack, 1'b1);
	endtask : setPtr

	// One write data byte
	task automatic wr(input logic [7:0] d, input logic expAck);
		i_mst.sendByte(d, 1'b1, ack);
		check("data ack", ack, expAck);
	endtask : wr

	// Read control byte after a Start
	task automatic startRd;
		i_mst.start();
		i_mst.sendByte(8'ha7, 1'b1, ack);
		check("read ctrl ack", ack, 1'b1);
	endtask : startRd

	// One read byte
	task automatic rdb(input logic mAck, input logic [7:0] exp);
		i_mst.recvByte(mAck, rd);
		check("read data", rd, exp);
	endtask : rdb

	// Stop and pointer check
	task automatic endTest(input string name, input logic [12:0] expPtr);
		i_mst.stop();
		check("pointer", ptr, expPtr);
		$display("test %s done", name);
	endtask : endTest

	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// Hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ============================================================
	// Test sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		check("reset pointer", ptr, 16'h0000);
		check("drive level", sdaOut, 1'b0);
		repeat (4) @(posedge sys_clk);
		setPtr(16'hfffe);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10 + 8'(i), 1'b1);
		end
		endTest("wrap write", 13'h0002);
		setPtr(16'h1ffe);
		startRd();
		rdb(1'b0, 8'h10);
		rdb(1'b0, 8'h11);
		rdb(1'b1, 8'h12);
		endTest("random read", 13'h0001);
		startRd();
		rdb(1'b1, 8'h13);
		endTest("current read", 13'h0002);
		setPtr(16'h1800);
		wr(8'h5a, 1'b1);
		endTest("guard fill", 13'h1801);
		wpPin <= 1'b1;
		setPtr(16'h1800);
		wr(8'ha5, 1'b0);
		wr(8'ha5, 1'b0);
		endTest("guarded write", 13'h1800);
		setPtr(16'h17ff);
		wr(8'h3c, 1'b1);
		wr(8'h3c, 1'b0);
		endTest("guard edge", 13'h1800);
		wpPin <= 1'b0;
		setPtr(16'h17ff);
		startRd();
		rdb(1'b0, 8'h3c);
		rdb(1'b1, 8'h5a);
		endTest("guard readback", 13'h1801);
		setPtr(16'h0100);
		wr(8'h11, 1'b1);
		wr(8'h22, 1'b1);
		endTest("abort fill", 13'h0102);
		setPtr(16'h0100);
		wr(8'h33, 1'b1);
		// Cut the last byte before its ack clock rises, by a save request
		i_mst.sendByte(8'h44, 1'b0, ack);
		powerLossSave <= 1'b1;
		repeat (6) @(posedge sys_clk);
		check("abort release", sdaOe, 1'b0);
		powerLossSave <= 1'b0;
		repeat (6) @(posedge sys_clk);
		setPtr(16'h0100);
		startRd();
		rdb(1'b0, 8'h33);
		rdb(1'b1, 8'h22);
		endTest("abort", 13'h0102);
		setPtr(16'h0200);
		powerLossSave <= 1'b1;
		i_mst.sendByte(8'h99, 1'b1, ack);
		check("save ack", ack, 1'b0);
		check("save release", sdaOe, 1'b0);
		powerLossSave <= 1'b0;
		endTest("save abort", 13'h0200);
		foreach (badCtrl[i]) begin
			i_mst.start();
			i_mst.sendByte(badCtrl[i], 1'b1, ack);
			check("bad ctrl ack", ack, 1'b0);
			i_mst.stop();
		end
		chipSelectPinHigh <= 1'b1;
		chipSelectPinLow <= 1'b0;
		i_mst.start();
		i_mst.sendByte(8'haa, 1'b1, ack);
		check("strap ctrl ack", ack, 1'b1);
		endTest("select", 13'h0200);
		wrap_up();
	end
endmodule : tb
